// ---- hdl/tec_pkg.sv ----
// Purpose: Shared constants and types of the timer/event counter
// Assumes: Registers are word indexes; byte address is four times the index
// Notes: Index, field positions and reset values are named once here
package tec_pkg;
	// Register indexes; byte addresses are four times these
	localparam logic [5:0] TEC_IDX_COUNT = 6'h0d;
	localparam logic [5:0] TEC_IDX_CTRL = 6'h0e;
	localparam logic [5:0] TEC_IDX_INTERRUPT_CONTROL = 6'h0b;
	// Control register fields
	localparam int TEC_CTRL_PSC_LSB = 0;
	localparam int TEC_CTRL_EDGE = 3;
	localparam int TEC_CTRL_ON = 4;
	localparam int TEC_CTRL_UNUSED = 5;
	localparam int TEC_CTRL_MODE_LSB = 6;
	// Interrupt control fields
	localparam int TEC_INTERRUPT_CONTROL_ETI = 2;
	localparam int TEC_INTERRUPT_CONTROL_TF = 5;
	// Reset values and top of the count
	localparam logic [7:0] TEC_CTRL_RST = 8'h08;
	localparam logic [7:0] TEC_COUNT_RST = 8'h00;
	localparam logic [7:0] TEC_COUNT_MAX = 8'hff;
	// Operating modes
	localparam logic [1:0] TEC_MODE_NONE = 2'h0;
	localparam logic [1:0] TEC_MODE_EVENT = 2'h1;
	localparam logic [1:0] TEC_MODE_TIMER = 2'h2;
	localparam logic [1:0] TEC_MODE_PULSE = 2'h3;
	// Pulse-width measurement states
	typedef enum logic {
		TEC_PW_WAIT,
		TEC_PW_RUN
	} tec_pw_e;
	// Whole state of the counter
	typedef struct packed {
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic [6:0] presc;
		logic [7:0] count;
		logic [7:0] preload;
		logic [2:0] psc;
		logic edge_sel;
		logic on;
		logic [1:0] mode;
		logic tf;
		logic timer_irq_enable;
		logic irq;
		logic tone;
		logic ovf;
		tec_pw_e pw;
		logic wr_pend;
		logic [5:0] wr_idx;
		logic [31:0] rdata;
	} tec_state_s;
endpackage

// ---- hdl/tec_timer_event_counter.sv ----
// Purpose: 8-bit count-up timer/event counter with preload, prescaler and three modes
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: Read data is captured in the address phase; a warm reset never reaches this block
//
// How it works
// (R1) Eight-bit up counter clocked by the pin or the prescaled system clock
// (R2) Writing the count word loads the preload; reading returns the live count
// (R3) Control bits 2:0 divide the system clock by 1 up to 128
// (R4) Control bit 3 picks the pin edge: 0 rising, 1 falling
// (R5) Control bit 4 enables counting
// (R6) Control bit 5 always reads as zero
// (R7) Control bits 7:6 pick event, timer or pulse mode; 00 idle
// (R8) Event mode counts pin edges; timer and pulse modes count prescaled ticks
// (R9) Overflow past FFH reloads from preload and sets the request flag
// (R10) Pulse mode starts on the active edge and stops on the return edge
// (R11) Pulse completion clears the enable bit; otherwise only software clears it
// (R12) Result holds after completion until software re-enables; edges, not levels
// (R13) Overflow in pulse mode also reloads and raises the request
// (R14) Overflow pulses a wake-up output for the halted core
// (R15) Cleared interrupt enable blocks the interrupt output in every mode
// (R16) Preload write also loads the counter while counting is off
// (R17) A read of the count blocks one count step for coherence
// (R18) Overflow feeds the tone output; prescaler drives the PWM time base
// (R19) Warm reset from watchdog leaves counter and control untouched
// (R20) Request flag stays set until serviced or cleared by software
// (R21) Tone output toggles on each overflow, half the overflow rate
// (R22) The pin is synchronised by two flops before edge detection
// (R23) Prescaler is a free-running seven-stage binary divider
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
module tec_timer_event_counter
	import tec_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic timer_event_pin_i,
	input wire logic irq_ack_i,
	output logic timer_irq_o,
	output logic wakeup_o,
	output logic overflow_pulse_o,
	output logic overflow_tone_out_o,
	output logic [6:0] pwm_time_base_o
);
	tec_state_s st;
	tec_state_s st_nxt;
	logic acc;
	logic rd_acc;
	logic [5:0] acc_idx;
	logic [7:0] mask;
	logic tick;
	logic rise;
	logic fall;
	logic act_edge;
	logic ret_edge;
	logic step;
	logic [7:0] wd;
	logic [7:0] ctrl_rd;

	// Bus decode of the address phase
	assign acc = hsel_i && htrans_i[1] && hready_i;
	assign rd_acc = acc && !hwrite_i;
	assign acc_idx = haddr_i[7:2];
	assign wd = hwdata_i[7:0];

	// Prescaler tap: tick when the low psc stages are all ones
	assign mask = 8'((8'h01 << st.psc) - 8'h01); // R3
	assign tick = ((st.presc & mask[6:0]) == mask[6:0]); // R23

	// Edge detection on the synchronised pin only
	assign rise = st.pin_s2 && !st.pin_prev; // R22
	assign fall = !st.pin_s2 && st.pin_prev;
	assign act_edge = st.edge_sel ? fall : rise; // R4
	assign ret_edge = st.edge_sel ? rise : fall;

	// Control register as software sees it
	assign ctrl_rd = {st.mode, 1'b0, st.on, st.edge_sel, st.psc}; // R6

	// Next-state logic
	always_comb begin
		st_nxt = st;
		step = 1'b0;
		st_nxt.pin_s1 = timer_event_pin_i;
		st_nxt.pin_s2 = st.pin_s1; // R22
		st_nxt.pin_prev = st.pin_s2;
		st_nxt.presc = st.presc + 7'h01; // R23
		st_nxt.ovf = 1'b0;
		// Counting source per mode
		if (st.on) begin // R5
			unique case (st.mode)
				TEC_MODE_EVENT: step = act_edge; // R8
				TEC_MODE_TIMER: step = tick; // R8
				TEC_MODE_PULSE: step = (st.pw == TEC_PW_RUN) && tick; // R8
				default: step = 1'b0; // R7
			endcase
		end
		// Pulse-width sequencing, edge triggered
		if (st.on && st.mode == TEC_MODE_PULSE) begin
			unique case (st.pw)
				TEC_PW_WAIT: begin
					if (act_edge) begin
						st_nxt.pw = TEC_PW_RUN; // R10
					end
				end
				TEC_PW_RUN: begin
					if (ret_edge) begin
						st_nxt.pw = TEC_PW_WAIT; // R10
						st_nxt.on = 1'b0; // R11
						step = 1'b0; // R12
					end
				end
			endcase
		end else begin
			st_nxt.pw = TEC_PW_WAIT;
		end
		// A count read in progress blocks the step
		if (rd_acc && acc_idx == TEC_IDX_COUNT) begin
			step = 1'b0; // R17
		end
		// Count and overflow with reload
		if (step) begin
			if (st.count == TEC_COUNT_MAX) begin
				st_nxt.count = st.preload; // R9 R13
				st_nxt.ovf = 1'b1; // R18
				st_nxt.tone = !st.tone; // R21
			end else begin
				st_nxt.count = st.count + 8'h01; // R1
			end
		end
		// Request flag cleared by service acknowledge
		if (irq_ack_i) begin
			st_nxt.tf = 1'b0; // R20
		end
		// Data phase of a write
		if (st.wr_pend) begin
			unique case (st.wr_idx)
				TEC_IDX_COUNT: begin
					st_nxt.preload = wd; // R2
					if (!st.on) begin
						st_nxt.count = wd; // R16
					end
				end
				TEC_IDX_CTRL: begin
					st_nxt.psc = wd[TEC_CTRL_PSC_LSB +: 3]; // R3
					st_nxt.edge_sel = wd[TEC_CTRL_EDGE]; // R4
					st_nxt.on = wd[TEC_CTRL_ON]; // R5 R11
					st_nxt.mode = wd[TEC_CTRL_MODE_LSB +: 2]; // R7
					st_nxt.pw = TEC_PW_WAIT; // R12
				end
				TEC_IDX_INTERRUPT_CONTROL: begin
					st_nxt.timer_irq_enable = wd[TEC_INTERRUPT_CONTROL_ETI];
					st_nxt.tf = wd[TEC_INTERRUPT_CONTROL_TF]; // R20
				end
				default: begin
				end
			endcase
		end
		// Overflow sets the flag, winning over any clear
		if (st_nxt.ovf) begin
			st_nxt.tf = 1'b1; // R9
		end
		st_nxt.irq = st_nxt.tf && st_nxt.timer_irq_enable; // R15
		// Address phase capture
		st_nxt.wr_pend = acc && hwrite_i;
		st_nxt.wr_idx = acc_idx;
		if (rd_acc) begin
			unique case (acc_idx)
				TEC_IDX_COUNT: st_nxt.rdata = {24'h000000, st.count}; // R2
				TEC_IDX_CTRL: st_nxt.rdata = {24'h000000, ctrl_rd}; // R6
				TEC_IDX_INTERRUPT_CONTROL: st_nxt.rdata = {26'h0000000, st.tf, 2'h0, st.timer_irq_enable, 2'h0};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	// State register; no warm reset input exists, so contents survive a watchdog wake
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin // R19
		if (!rst_n_i) begin
			st <= '0;
			st.count <= TEC_COUNT_RST;
			st.preload <= TEC_COUNT_RST;
			st.psc <= TEC_CTRL_RST[TEC_CTRL_PSC_LSB +: 3];
			st.edge_sel <= TEC_CTRL_RST[TEC_CTRL_EDGE];
			st.on <= TEC_CTRL_RST[TEC_CTRL_ON];
			st.mode <= TEC_CTRL_RST[TEC_CTRL_MODE_LSB +: 2];
			st.pw <= TEC_PW_WAIT;
		end else begin
			st <= st_nxt;
		end
	end

	// Outputs straight from state
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = st.rdata;
	assign timer_irq_o = st.irq; // R15
	assign wakeup_o = st.ovf; // R14
	assign overflow_pulse_o = st.ovf; // R18
	assign overflow_tone_out_o = st.tone; // R21
	assign pwm_time_base_o = st.presc; // R18

	// Checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence ovf_seq;
		st.ovf && !$past(st.wr_pend);
	endsequence

	sequence pw_end_seq;
		st.on && st.mode == TEC_MODE_PULSE && st.pw == TEC_PW_RUN && ret_edge && !st.wr_pend;
	endsequence

	sequence cnt_read_seq;
		rd_acc && acc_idx == TEC_IDX_COUNT && !st.wr_pend;
	endsequence

	ovf_reload_a: assert property (ovf_seq |-> st.count == st.preload) // R9
		else $error("overflow did not reload from preload");
	ovf_flag_a: assert property (st.ovf |-> st.tf) // R9
		else $error("overflow did not set the request flag");
	tone_toggle_a: assert property (st.ovf |-> st.tone != $past(st.tone)) // R21
		else $error("tone did not toggle on overflow");
	tone_hold_a: assert property (!st.ovf && $past(rst_n_i) |-> st.tone == $past(st.tone)) // R21
		else $error("tone changed without overflow");
	ctrl_zero_a: assert property (rd_acc && acc_idx == TEC_IDX_CTRL |=> hrdata_o[TEC_CTRL_UNUSED] == 1'b0) // R6
		else $error("unused control bit read as one");
	irq_gate_a: assert property (timer_irq_o |-> st.timer_irq_enable && st.tf) // R15
		else $error("interrupt raised while disabled");
	read_block_a: assert property (cnt_read_seq |=> st.count == $past(st.count)) // R17
		else $error("count moved during a read");
	pw_stop_a: assert property (pw_end_seq |=> !st.on ##1 (!st.on || $past(st.wr_pend))) // R11
		else $error("pulse end did not clear enable");
	off_load_a: assert property (st.wr_pend && st.wr_idx == TEC_IDX_COUNT && !st.on |=> st.count == st.preload) // R16
		else $error("preload write did not load the stopped counter");
	off_hold_a: assert property (!st.on && !st.wr_pend |=> st.count == $past(st.count)) // R5
		else $error("counter moved while disabled");
	wake_pulse_a: assert property (wakeup_o |=> !wakeup_o) // R14
		else $error("wake-up wider than one cycle");

	// Timing seen by the checks below:
	// a step decided in cycle t shows in the count at t+1;
	// a write lands one cycle after its address phase, when wr_pend is high;
	// a count read in its address phase freezes the count for that cycle;
	// the pin reaches pin_s2 two edges after it is sampled.
	// Checks that expect one plain step therefore exclude cycles with a
	// landing write, a blocking read or a pending reload, and the
	// reload checks take the preload value of the cycle before.

	// Helpers: a count read in progress, and a step with no other effect on it
	logic cnt_rd;
	logic step_free;
	assign cnt_rd = rd_acc && acc_idx == TEC_IDX_COUNT;
	assign step_free = !st.wr_pend && !cnt_rd && st.count != TEC_COUNT_MAX;

	// Timer mode tick that must advance the count by one
	sequence timer_tick_seq;
		st.on && st.mode == TEC_MODE_TIMER && tick && step_free;
	endsequence

	// Rising pin edge with rising edges selected in event mode
	sequence rise_evt_seq;
		st.on && st.mode == TEC_MODE_EVENT && !st.edge_sel && st.pin_s2 && !st.pin_prev && step_free;
	endsequence

	// Falling pin edge with falling edges selected in event mode
	sequence fall_evt_seq;
		st.on && st.mode == TEC_MODE_EVENT && st.edge_sel && !st.pin_s2 && st.pin_prev && step_free;
	endsequence

	// Tick while a pulse is being measured and has not ended
	sequence pw_tick_seq;
		st.on && st.mode == TEC_MODE_PULSE && st.pw == TEC_PW_RUN && tick && !ret_edge && step_free;
	endsequence

	// Active edge that arms a pulse measurement
	sequence pw_arm_seq;
		st.on && st.mode == TEC_MODE_PULSE && st.pw == TEC_PW_WAIT && act_edge && !st.wr_pend;
	endsequence

	// Timer tick at the top of the count
	sequence timer_wrap_seq;
		st.on && st.mode == TEC_MODE_TIMER && tick && st.count == TEC_COUNT_MAX && !st.wr_pend && !cnt_rd;
	endsequence

	// Measurement tick at the top of the count
	sequence pulse_wrap_seq;
		st.on && st.mode == TEC_MODE_PULSE && st.pw == TEC_PW_RUN && tick && !ret_edge &&
			st.count == TEC_COUNT_MAX && !st.wr_pend && !cnt_rd;
	endsequence

	// Timer mode counts every tick
	timer_step_a: assert property (timer_tick_seq |=> st.count == $past(st.count) + 8'h01) // R8
		else $error("timer tick did not advance the count");

	// Rising edges counted when selected
	rise_count_a: assert property (rise_evt_seq |=> st.count == $past(st.count) + 8'h01) // R4
		else $error("rising pin edge not counted");

	// Falling edges counted when selected
	fall_count_a: assert property (fall_evt_seq |=> st.count == $past(st.count) + 8'h01) // R4
		else $error("falling pin edge not counted");

	// Event mode ignores the prescaler
	event_ignore_a: assert property (st.on && st.mode == TEC_MODE_EVENT && !act_edge && !st.wr_pend
		|=> st.count == $past(st.count)) // R8
		else $error("event count moved without a pin edge");

	// Measurement counts ticks while running
	pw_count_a: assert property (pw_tick_seq |=> st.count == $past(st.count) + 8'h01) // R10
		else $error("pulse measurement missed a tick");

	// Active edge starts the measurement
	pw_arm_a: assert property (pw_arm_seq |=> st.pw == TEC_PW_RUN) // R10
		else $error("active edge did not start the measurement");

	// Waiting or finished measurement holds the count
	pw_wait_a: assert property (st.mode == TEC_MODE_PULSE && st.pw == TEC_PW_WAIT && !st.wr_pend
		|=> st.count == $past(st.count)) // R12
		else $error("count moved outside a measurement");

	// Unused mode never counts
	mode_idle_a: assert property (st.mode == TEC_MODE_NONE && !st.wr_pend |=> st.count == $past(st.count)) // R7
		else $error("count moved in the unused mode");

	// Timer overflow reloads and pulses
	timer_wrap_a: assert property (timer_wrap_seq |=> st.ovf && st.count == $past(st.preload)) // R9
		else $error("timer overflow did not reload");

	// Measurement overflow reloads and requests
	pulse_wrap_a: assert property (pulse_wrap_seq |=> st.tf && st.count == $past(st.preload)) // R13
		else $error("measurement overflow did not reload");

	// Enable stays set outside pulse mode
	on_keep_a: assert property (st.on && st.mode != TEC_MODE_PULSE && !st.wr_pend |=> st.on) // R11
		else $error("enable cleared by hardware outside pulse mode");

	// Request flag holds until serviced or written
	flag_hold_a: assert property (st.tf && !irq_ack_i && !st.wr_pend |=> st.tf) // R20
		else $error("request flag dropped by itself");

	// Service acknowledge clears the flag unless an overflow wins
	ack_clear_a: assert property (irq_ack_i && !st.wr_pend |=> !st.tf || st.ovf) // R20
		else $error("acknowledge did not clear the flag");

	// Prescaler runs freely
	presc_run_a: assert property ($past(rst_n_i) |-> st.presc == 7'($past(st.presc) + 7'h01)) // R23
		else $error("prescaler did not advance");

	// Division by one ticks every cycle
	psc_full_a: assert property (st.psc == 3'h0 |-> tick) // R3
		else $error("undivided clock missed a tick");

	// Division by 128 ticks only at the top stage value
	psc_slow_a: assert property (tick && st.psc == 3'h7 |-> st.presc == 7'h7f) // R3
		else $error("divide by 128 ticked early");

	// Pin passes two flops before edge detection
	sync_two_a: assert property ($past(rst_n_i, 2) && $past(rst_n_i)
		|-> st.pin_s2 == $past(timer_event_pin_i, 2)) // R22
		else $error("pin synchroniser depth wrong");

	// Count word write always lands in the preload
	preload_wr_a: assert property (st.wr_pend && st.wr_idx == TEC_IDX_COUNT |=> st.preload == $past(wd)) // R16
		else $error("count word write missed the preload");

	// Count read returns the live count
	read_live_a: assert property (cnt_rd |=> hrdata_o == {24'h000000, $past(st.count)}) // R2
		else $error("count read returned a stale value");

	// Control read returns the mode bits
	ctrl_mode_a: assert property (rd_acc && acc_idx == TEC_IDX_CTRL |=> hrdata_o[7:6] == $past(st.mode)) // R7
		else $error("control read lost the mode bits");

endmodule // tec_timer_event_counter

// ---- verification/tb_timer_event_counter.sv ----
// Purpose: Self-checking bench of the timer/event counter
// Assumes: Zero-wait AHB slave, pin model on the event input
// Notes: Expected values come from integer models in this file
`timescale 1ns/10ps
module tb_timer_event_counter;
	import tec_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic hsel = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic ack = 1'h0;
	logic go = 1'h0;
	logic [7:0] wid = 8'h1;
	logic hready, hresp, pin, busy, irq, wake, ovf, tone, t0;
	logic [31:0] hrdata, r;
	logic [6:0] pwm, ptb;
	logic [7:0] b;
	int n_mismatch = 0;
	int cmp_count = 0;
	int seed = 98973;
	int n, k;
	int q[$];
	tec_timer_event_counter dut (.clk_sys_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .timer_event_pin_i(pin), .irq_ack_i(ack),
		.timer_irq_o(irq), .wakeup_o(wake), .overflow_pulse_o(ovf), .overflow_tone_out_o(tone),
		.pwm_time_base_o(pwm));
	tec_pin_model pm (.clk_sys_i(clk), .go_i(go), .width_i(wid), .pin_o(pin), .busy_o(busy));
	// System clock, 50 ns period
	always #25 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %b got %b", nm, e, g);
		end
	endtask
	// One AHB single transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, idx, 2'h0};
		do @(posedge clk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hready !== 1'h1);
		rd = hrdata;
		chk_bit("hresp", 1'h0, hresp);
	endtask
	task automatic pulse(input logic [7:0] w);
		wid <= w;
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		do @(posedge clk); while (busy);
		repeat (8) @(posedge clk);
	endtask
	// Count cycles up to the next overflow pulse
	task automatic wait_ovf;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ovf !== 1'h1 && n < 5000);
		if (ovf !== 1'h1) begin
			n_mismatch++;
		end
		chk_bit("wake", 1'h1, wake);
	endtask
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		bus(0, TEC_IDX_CTRL, 8'h0, r);
		chk("ctrl", {24'h0, TEC_CTRL_RST}, r);
		bus(1, TEC_IDX_CTRL, 8'h28, r);
		bus(0, TEC_IDX_CTRL, 8'h0, r);
		chk("ctrl", 32'h08, r);
		bus(0, 6'h01, 8'h0, r);
		chk("unmapped", 32'h0, r);
		ptb = pwm;
		@(posedge clk);
		chk("pwm", {25'h0, ptb + 7'h1}, {25'h0, pwm});
		$display("test registers done");
		for (k = 0; k < 8; k++) begin
			b = 8'hf0 | 8'($random(seed));
			bus(1, TEC_IDX_COUNT, b, r);
			bus(1, TEC_IDX_CTRL, {5'h12, 3'(k)}, r);
			wait_ovf;
			t0 = tone;
			wait_ovf;
			chk("period", (256 - b) << k, 32'(n));
			chk_bit("tone", !t0, tone);
			bus(1, TEC_IDX_CTRL, 8'h08, r);
			bus(0, TEC_IDX_INTERRUPT_CONTROL, 8'h0, r);
			chk_bit("flag", 1'h1, r[5]);
			bus(1, TEC_IDX_INTERRUPT_CONTROL, 8'h0, r);
		end
		$display("test timer done");
		bus(1, TEC_IDX_COUNT, 8'hfe, r);
		bus(1, TEC_IDX_INTERRUPT_CONTROL, 8'h04, r);
		bus(1, TEC_IDX_CTRL, 8'h90, r);
		wait_ovf;
		bus(1, TEC_IDX_CTRL, 8'h08, r);
		chk_bit("irq", 1'h1, irq);
		ack <= 1'h1;
		@(posedge clk);
		ack <= 1'h0;
		repeat (2) @(posedge clk);
		chk_bit("irq ack", 1'h0, irq);
		bus(1, TEC_IDX_INTERRUPT_CONTROL, 8'h20, r);
		bus(0, TEC_IDX_INTERRUPT_CONTROL, 8'h0, r);
		chk("interrupt_control", 32'h20, r);
		chk_bit("irq off", 1'h0, irq);
		bus(1, TEC_IDX_INTERRUPT_CONTROL, 8'h0, r);
		$display("test interrupt done");
		b = 8'($random(seed)) & 8'h7f;
		bus(1, TEC_IDX_COUNT, b, r);
		bus(1, TEC_IDX_CTRL, 8'h50, r);
		repeat (1 + ($random(seed) & 7)) q.push_back(2 + ($random(seed) & 3));
		while (q.size() > 0) begin
			pulse(8'(q.pop_front()));
			b++;
		end
		bus(1, TEC_IDX_COUNT, 8'h11, r);
		bus(0, TEC_IDX_COUNT, 8'h0, r);
		chk("events", {24'h0, b}, r);
		bus(0, TEC_IDX_CTRL, 8'h0, r);
		chk("ctrl on", 32'h50, r);
		bus(1, TEC_IDX_CTRL, 8'h08, r);
		bus(1, TEC_IDX_COUNT, b, r);
		bus(1, TEC_IDX_CTRL, 8'h58, r);
		pulse(8'h03);
		pulse(8'h03);
		bus(0, TEC_IDX_COUNT, 8'h0, r);
		chk("fall events", {24'h0, b + 8'h02}, r);
		bus(1, TEC_IDX_CTRL, 8'h08, r);
		bus(1, TEC_IDX_COUNT, 8'h33, r);
		bus(1, TEC_IDX_CTRL, 8'h10, r);
		repeat (40) @(posedge clk);
		bus(0, TEC_IDX_COUNT, 8'h0, r);
		chk("idle mode", 32'h33, r);
		bus(1, TEC_IDX_CTRL, 8'h08, r);
		$display("test event done");
		bus(1, TEC_IDX_COUNT, 8'h0, r);
		bus(1, TEC_IDX_CTRL, 8'hd0, r);
		pulse(8'h14);
		bus(0, TEC_IDX_COUNT, 8'h0, r);
		chk_bit("width", 1'h1, r >= 19 && r <= 21);
		b = r[7:0];
		bus(0, TEC_IDX_CTRL, 8'h0, r);
		chk("ctrl done", 32'hc0, r);
		pulse(8'h05);
		bus(0, TEC_IDX_COUNT, 8'h0, r);
		chk("held", {24'h0, b}, r);
		bus(1, TEC_IDX_COUNT, 8'h0, r);
		bus(1, TEC_IDX_CTRL, 8'hd8, r);
		pulse(8'h03);
		pulse(8'h03);
		bus(0, TEC_IDX_COUNT, 8'h0, r);
		chk_bit("low width", 1'h1, r >= 8 && r <= 10);
		bus(0, TEC_IDX_CTRL, 8'h0, r);
		chk("ctrl low done", 32'hc8, r);
		$display("test pulse done");
		report_and_stop;
	end
endmodule // tb_timer_event_counter

// ---- verification/tec_pin_model.sv ----
// Purpose: Model of the pulse source on the timer event pin
// Assumes: Pin idles low and is always driven
// Notes: One high pulse per go request; busy holds until it ends
`timescale 1ns/10ps
module tec_pin_model (
	input wire logic clk_sys_i,
	input wire logic go_i,
	input wire logic [7:0] width_i,
	output logic pin_o,
	output logic busy_o
);
	int left = 0;
	initial pin_o = 1'h0;
	// One pulse of the asked width; its edges carry the events
	always @(posedge clk_sys_i) begin
		if (left > 0) begin
			left <= left - 1;
			if (left == 1) begin
				pin_o <= 1'h0;
			end
		end else if (go_i) begin
			left <= width_i;
			pin_o <= 1'h1;
		end
	end
	assign busy_o = (left != 0) || go_i;
endmodule // tec_pin_model
